// ### ledsd_pkg.sv
package ledsd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register bus
  localparam int          AXI_AW       = 18;
  typedef logic [AXI_AW-1:0] ledsd_addr_t;
  typedef logic [15:0]       ledsd_idx_t;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // register indices; byte address is four times the index
  localparam ledsd_idx_t  PINFN_IDX    = 16'h0092;
  localparam ledsd_idx_t  DCTL_IDX     = 16'h00b1;
  localparam ledsd_idx_t  DCTL2_IDX    = 16'h00b2;
  localparam ledsd_idx_t  RAM_BASE_IDX = 16'hf000;

  ////////////////////////////////////////////////////////////////////////////
  // geometry
  localparam int          NUM_SEG      = 27;
  localparam int          LED_SEGS     = 10;
  localparam int          NUM_COM      = 4;

  // field positions
  localparam int          P2H_LSB      = 5;
  localparam int          P2L_LSB      = 3;
  localparam int          P0_LSB       = 0;
  localparam int          DSP_ON_BIT   = 7;
  localparam int          DUTY_LSB     = 4;
  localparam int          CLKSEL_LSB   = 2;
  localparam int          FMR_LSB      = 0;
  localparam int          LEDSEL_BIT   = 5;
  localparam int          POL_BIT      = 4;

  // reset values and writable bits
  localparam logic [7:0]  PINFN_RST    = 8'h7f;
  localparam logic [7:0]  DCTL_RST     = 8'h12;
  localparam logic [7:0]  DCTL2_RST    = 8'h11;
  localparam logic [7:0]  PINFN_WMASK  = 8'h7f;
  localparam logic [7:0]  DCTL2_WMASK  = 8'h3f;

  // duty codes
  localparam logic [2:0]  DUTY_THIRD   = 3'h0;
  localparam logic [2:0]  DUTY_QUARTER = 3'h1;

  // scan clock sources, in field code order
  typedef enum logic [1:0] {CLK_SLOW, CLK_SLOW_DIV2, CLK_SUB_DIV128,
                            CLK_SUB_DIV256} ledsd_clk_sel_t;
  localparam logic [8:0]  SUB_DIV_LO   = 9'h080;
  localparam logic [8:0]  SUB_DIV_HI   = 9'h100;

  // scan ticks per common slot for each frame rate code
  localparam logic [5:0]  SLOT_TICKS_0 = 6'h08;
  localparam logic [5:0]  SLOT_TICKS_1 = 6'h0c;
  localparam logic [5:0]  SLOT_TICKS_2 = 6'h10;
  localparam logic [5:0]  SLOT_TICKS_3 = 6'h18;
  localparam logic [5:0]  DEAD_TICKS   = 6'h01;

endpackage : ledsd_pkg

// ### ledsd_regbus_if.sv
`timescale 1ns/1ps
interface ledsd_regbus_if;
  import ledsd_pkg::*;
  logic        wr_en;
  ledsd_addr_t wr_addr;
  logic [7:0]  wr_data;
  logic        wr_hit;
  logic        rd_en;
  ledsd_addr_t rd_addr;
  logic [7:0]  rd_data;
  logic        rd_hit;
  modport bus  (output wr_en, wr_addr, wr_data, rd_en, rd_addr,
                input  wr_hit, rd_data, rd_hit);
  modport regs (input  wr_en, wr_addr, wr_data, rd_en, rd_addr,
                output wr_hit, rd_data, rd_hit);
endinterface : ledsd_regbus_if

// ### ledsd_axil_slave.sv
`timescale 1ns/1ps
module ledsd_axil_slave
  import ledsd_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write channels
  input  wire ledsd_addr_t s_awaddr,
  input  wire logic        s_awvalid,
  output      logic        s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output      logic        s_wready,
  output      logic [1:0]  s_bresp,
  output      logic        s_bvalid,
  input  wire logic        s_bready,
  // read channels
  input  wire ledsd_addr_t s_araddr,
  input  wire logic        s_arvalid,
  output      logic        s_arready,
  output      logic [31:0] s_rdata,
  output      logic [1:0]  s_rresp,
  output      logic        s_rvalid,
  input  wire logic        s_rready,
  // register side
  ledsd_regbus_if.bus      rb
);
  import ledsd_pkg::*;

  logic        aw_held_ff;
  logic        w_held_ff;
  ledsd_addr_t awaddr_ff;
  logic [7:0]  wdata_ff;
  logic        wlane_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [1:0]  rresp_ff;
  logic [7:0]  rdata_ff;

  assign s_awready  = !aw_held_ff && !bvalid_ff;
  assign s_wready   = !w_held_ff && !bvalid_ff;
  assign s_arready  = !rvalid_ff;
  assign s_bvalid   = bvalid_ff;
  assign s_bresp    = bresp_ff;
  assign s_rvalid   = rvalid_ff;
  assign s_rresp    = rresp_ff;
  assign s_rdata    = {24'h000000, rdata_ff};
  // a write without byte lane 0 is acknowledged but stores nothing
  assign rb.wr_en   = aw_held_ff && w_held_ff && !bvalid_ff && wlane_ff;
  assign rb.wr_addr = awaddr_ff;
  assign rb.wr_data = wdata_ff;
  assign rb.rd_en   = s_arvalid && s_arready;
  assign rb.rd_addr = s_araddr;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      wlane_ff   <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end
    else
    begin
      if (s_awvalid && s_awready)
      begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= s_awaddr;
      end
      if (s_wvalid && s_wready)
      begin
        w_held_ff <= 1'b1;
        wdata_ff  <= s_wdata[7:0];
        wlane_ff  <= s_wstrb[0];
      end
      if (aw_held_ff && w_held_ff && !bvalid_ff)
      begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= rb.wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_ff && s_bready)
        bvalid_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= RESP_OKAY;
    end
    else if (rb.rd_en)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= rb.rd_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_ff  <= rb.rd_data;
    end
    else if (rvalid_ff && s_rready)
      rvalid_ff <= 1'b0;
  end

endmodule : ledsd_axil_slave

// ### ledsd_tick_gen.sv
`timescale 1ns/1ps
module ledsd_tick_gen
  import ledsd_pkg::*;
(
  // clock and reset
  input  wire logic           aclk,
  input  wire logic           aresetn,
  // slow clock pins
  input  wire logic           slow_clock,
  input  wire logic           sub_clock,
  // control
  input  wire logic           run,
  input  wire ledsd_clk_sel_t clk_sel,
  // scan tick, one cycle
  output      logic           tick
);
  import ledsd_pkg::*;

  logic [2:0] slow_sync_ff;
  logic [2:0] sub_sync_ff;
  logic       half_ff;
  logic [8:0] sub_cnt_ff;
  logic       slow_rise;
  logic       sub_rise;
  logic [8:0] sub_lim;
  logic       sub_wrap;

  // bit 0 is the metastable stage; bits 1 and 2 feed the edge detect
  assign slow_rise = slow_sync_ff[1] && !slow_sync_ff[2];
  assign sub_rise  = sub_sync_ff[1] && !sub_sync_ff[2];
  assign sub_lim   = (clk_sel == CLK_SUB_DIV256) ? SUB_DIV_HI : SUB_DIV_LO;
  // >= so a switch from /256 to /128 never runs past the limit
  assign sub_wrap  = sub_cnt_ff >= sub_lim - 9'h001;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      slow_sync_ff <= 3'h0;
      sub_sync_ff  <= 3'h0;
    end
    else
    begin
      slow_sync_ff <= {slow_sync_ff[1:0], slow_clock};
      sub_sync_ff  <= {sub_sync_ff[1:0], sub_clock};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
    begin
      half_ff    <= 1'b0;
      sub_cnt_ff <= 9'h000;
    end
    else
    begin
      if (slow_rise)
        half_ff <= !half_ff;
      if (sub_rise)
        sub_cnt_ff <= sub_wrap ? 9'h000 : sub_cnt_ff + 9'h001;
    end
  end

  assign tick = run && (clk_sel[1] ? sub_rise && sub_wrap
                       : slow_rise && (half_ff || clk_sel == CLK_SLOW));

endmodule : ledsd_tick_gen

// ### ledsd_top.sv
// Notes on behaviour
// - pin bits 6:5 map port2 pins 4-6
// - pin bits 4:3 map port2 pins 1-3
// - pin bits 2:0 map top N port0 pins
// - ram byte n is segment n, bit k common k
// - led select bit swaps lcd for led drive
// - led mode: segments 0-9, commons 0-3
// - led commons active low with dead time
// - polarity bit sets lit level, resets one
// - led reuses ram and control fields
// - display on bit enables driver, resets off
// - duty 000 third, 001 quarter
// - clock field selects scan clock source
// - frame rate field scales slot length
`timescale 1ns/1ps
module ledsd_top
  import ledsd_pkg::*;
(
  // clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // axi4-lite write
  input  wire ledsd_addr_t         s_awaddr,
  input  wire logic                s_awvalid,
  output      logic                s_awready,
  input  wire logic [31:0]         s_wdata,
  input  wire logic [3:0]          s_wstrb,
  input  wire logic                s_wvalid,
  output      logic                s_wready,
  output      logic [1:0]          s_bresp,
  output      logic                s_bvalid,
  input  wire logic                s_bready,
  // axi4-lite read
  input  wire ledsd_addr_t         s_araddr,
  input  wire logic                s_arvalid,
  output      logic                s_arready,
  output      logic [31:0]         s_rdata,
  output      logic [1:0]          s_rresp,
  output      logic                s_rvalid,
  input  wire logic                s_rready,
  // scan clock pins
  input  wire logic                slow_clock,
  input  wire logic                sub_clock,
  // display drive
  output      logic [NUM_COM-1:0]  common_output,
  output      logic [NUM_SEG-1:0]  segment_output,
  output      logic                light_emitter_active,
  // pin function, high where a pin is a segment
  output      logic [6:0]          port0_segment_en,
  output      logic [6:0]          port2_segment_en
);
  import ledsd_pkg::*;

  typedef enum {ST_IDLE, ST_DEAD, ST_DRIVE} ledsd_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers
  function automatic logic idx_is(input ledsd_addr_t a,
                                  input ledsd_idx_t  idx);
    idx_is = (a[1:0] == 2'h0) && (a[AXI_AW-1:2] == idx);
  endfunction : idx_is

  function automatic logic ram_hit(input ledsd_addr_t a);
    ram_hit = (a[1:0] == 2'h0) && (a[AXI_AW-1:2] >= RAM_BASE_IDX) &&
              (a[AXI_AW-1:2] < RAM_BASE_IDX + 16'(NUM_SEG));
  endfunction : ram_hit

  function automatic logic [4:0] ram_sel(input ledsd_addr_t a);
    ledsd_idx_t off;
    off     = a[AXI_AW-1:2] - RAM_BASE_IDX;
    ram_sel = off[4:0];
  endfunction : ram_sel

  // the first four segment bytes hold only their low commons
  function automatic logic [7:0] ram_mask(input logic [4:0] n);
    unique case (n)
      5'h00:   ram_mask = 8'h0f;
      5'h01:   ram_mask = 8'h1f;
      5'h02:   ram_mask = 8'h3f;
      5'h03:   ram_mask = 8'h7f;
      default: ram_mask = 8'hff;
    endcase
  endfunction : ram_mask

  // n segment pins counted down from the top pin
  function automatic logic [6:0] top_pins(input logic [2:0] n);
    top_pins = 7'(14'h3f80 >> n);
  endfunction : top_pins

  function automatic logic [2:0] top3(input logic [1:0] n);
    top3 = 3'(6'h38 >> n);
  endfunction : top3

  ////////////////////////////////////////////////////////////////////////////
  // registers and wiring
  ledsd_regbus_if rb ();

  logic [7:0]         pinfn_ff;
  logic [7:0]         dctl_ff;
  logic [7:0]         dctl2_ff;
  logic [7:0]         ram_ff [NUM_SEG];
  ledsd_state_t       state_ff;
  ledsd_state_t       nxt_state;
  logic [1:0]         com_idx_ff;
  logic [1:0]         nxt_com_idx;
  logic [5:0]         tick_cnt_ff;
  logic [5:0]         nxt_tick_cnt;
  logic               inv_ff;
  logic               nxt_inv;
  logic [NUM_COM-1:0] com_ff;
  logic [NUM_COM-1:0] nxt_com;
  logic [NUM_SEG-1:0] seg_ff;
  logic [NUM_SEG-1:0] nxt_seg;
  logic [6:0]         p0_en_ff;
  logic [6:0]         p2_en_ff;

  logic               disp_on;
  logic               led_mode;
  logic               led_pol;
  logic [2:0]         duty;
  logic [1:0]         last_com;
  logic [5:0]         slot_len;
  logic               tick;
  logic               slot_end;

  assign disp_on  = dctl_ff[DSP_ON_BIT];
  assign led_mode = dctl2_ff[LEDSEL_BIT];
  assign led_pol  = dctl2_ff[POL_BIT];
  assign duty     = dctl_ff[DUTY_LSB+2:DUTY_LSB];
  // any code but quarter duty scans as third duty
  assign last_com = (duty == DUTY_QUARTER) ? 2'h3 : 2'h2;

  always_comb
  begin
    unique case (dctl_ff[FMR_LSB+1:FMR_LSB])
      2'h0:    slot_len = SLOT_TICKS_0;
      2'h1:    slot_len = SLOT_TICKS_1;
      2'h2:    slot_len = SLOT_TICKS_2;
      default: slot_len = SLOT_TICKS_3;
    endcase
  end

  // >= so a shorter slot chosen mid-slot ends at the next tick, not after a wrap
  assign slot_end             = tick && (tick_cnt_ff >= slot_len - 6'h01);
  assign common_output        = com_ff;
  assign segment_output       = seg_ff;
  assign light_emitter_active = led_mode;
  assign port0_segment_en     = p0_en_ff;
  assign port2_segment_en     = p2_en_ff;

  ledsd_axil_slave u_slave (
    .aclk,
    .aresetn,
    .s_awaddr,
    .s_awvalid,
    .s_awready,
    .s_wdata,
    .s_wstrb,
    .s_wvalid,
    .s_wready,
    .s_bresp,
    .s_bvalid,
    .s_bready,
    .s_araddr,
    .s_arvalid,
    .s_arready,
    .s_rdata,
    .s_rresp,
    .s_rvalid,
    .s_rready,
    .rb        (rb.bus)
  );

  // scan clock stops while display is off
  ledsd_tick_gen u_tick (
    .aclk,
    .aresetn,
    .slow_clock,
    .sub_clock,
    .run        (disp_on),
    .clk_sel    (ledsd_clk_sel_t'(dctl_ff[CLKSEL_LSB+1:CLKSEL_LSB])),
    .tick       (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register file
  assign rb.wr_hit = idx_is(rb.wr_addr, PINFN_IDX) ||
                     idx_is(rb.wr_addr, DCTL_IDX) ||
                     idx_is(rb.wr_addr, DCTL2_IDX) || ram_hit(rb.wr_addr);
  assign rb.rd_hit = idx_is(rb.rd_addr, PINFN_IDX) ||
                     idx_is(rb.rd_addr, DCTL_IDX) ||
                     idx_is(rb.rd_addr, DCTL2_IDX) || ram_hit(rb.rd_addr);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pinfn_ff <= PINFN_RST;
      dctl_ff  <= DCTL_RST;
      dctl2_ff <= DCTL2_RST;
    end
    else if (rb.wr_en)
    begin
      if (idx_is(rb.wr_addr, PINFN_IDX))
        pinfn_ff <= rb.wr_data & PINFN_WMASK;
      if (idx_is(rb.wr_addr, DCTL_IDX))
        dctl_ff <= rb.wr_data;
      if (idx_is(rb.wr_addr, DCTL2_IDX))
        dctl2_ff <= rb.wr_data & DCTL2_WMASK;
    end
  end

  // ram has no reset; contents survive a display off
  always_ff @(posedge aclk)
  begin
    if (rb.wr_en && ram_hit(rb.wr_addr))
      ram_ff[ram_sel(rb.wr_addr)] <=
        rb.wr_data & ram_mask(ram_sel(rb.wr_addr));
  end

  always_comb
  begin
    rb.rd_data = 8'h00;
    if (idx_is(rb.rd_addr, PINFN_IDX))
      rb.rd_data = pinfn_ff;
    else if (idx_is(rb.rd_addr, DCTL_IDX))
      rb.rd_data = dctl_ff;
    else if (idx_is(rb.rd_addr, DCTL2_IDX))
      rb.rd_data = dctl2_ff;
    else if (ram_hit(rb.rd_addr))
      rb.rd_data = ram_ff[ram_sel(rb.rd_addr)];
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin function decode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      p0_en_ff <= 7'h00;
      p2_en_ff <= 7'h00;
    end
    else
    begin
      p0_en_ff <= top_pins(pinfn_ff[P0_LSB+2:P0_LSB]);
      p2_en_ff <= {top3(pinfn_ff[P2H_LSB+1:P2H_LSB]),
                   top3(pinfn_ff[P2L_LSB+1:P2L_LSB]), 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // scan sequencer
  always_comb
  begin
    nxt_state    = state_ff;
    nxt_com_idx  = com_idx_ff;
    nxt_tick_cnt = tick_cnt_ff;
    nxt_inv      = inv_ff;
    if (!disp_on)
    begin
      nxt_state    = ST_IDLE;
      nxt_com_idx  = 2'h0;
      nxt_tick_cnt = 6'h00;
      nxt_inv      = 1'b0;
    end
    else
    begin
      unique case (state_ff)
        ST_IDLE:
          nxt_state = led_mode ? ST_DEAD : ST_DRIVE;
        ST_DEAD, ST_DRIVE:
        begin
          if (tick)
            nxt_tick_cnt = tick_cnt_ff + 6'h01;
          if (state_ff == ST_DEAD && tick &&
              tick_cnt_ff == DEAD_TICKS - 6'h01)
            nxt_state = ST_DRIVE;
          if (slot_end)
          begin
            nxt_tick_cnt = 6'h00;
            nxt_state    = led_mode ? ST_DEAD : ST_DRIVE;
            if (com_idx_ff >= last_com)
            begin
              nxt_com_idx = 2'h0;
              nxt_inv     = !inv_ff;
            end
            else
              nxt_com_idx = com_idx_ff + 2'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff    <= ST_IDLE;
      com_idx_ff  <= 2'h0;
      tick_cnt_ff <= 6'h00;
      inv_ff      <= 1'b0;
    end
    else
    begin
      state_ff    <= nxt_state;
      com_idx_ff  <= nxt_com_idx;
      tick_cnt_ff <= nxt_tick_cnt;
      inv_ff      <= nxt_inv;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output drive
  always_comb
  begin
    nxt_com = led_mode ? {NUM_COM{1'b1}} : {NUM_COM{1'b0}};
    nxt_seg = led_mode ? {NUM_SEG{!led_pol}} : {NUM_SEG{1'b0}};
    if (state_ff != ST_IDLE)
    begin
      if (led_mode)
      begin
        // only the drive phase pulls a common low; dead time blanks all
        if (state_ff == ST_DRIVE)
          nxt_com[com_idx_ff] = 1'b0;
        // segments follow the slot through dead time too, so a
        // uniformly filled byte gives a steady level
        for (int s = 0; s < LED_SEGS; s++)
          nxt_seg[s] = !(ram_ff[s][com_idx_ff] ^ led_pol);
      end
      else
      begin
        // digital lcd frame: selected common high, ac inverted per frame
        nxt_com[com_idx_ff] = 1'b1;
        nxt_com = nxt_com ^ {NUM_COM{inv_ff}};
        for (int s = 0; s < NUM_SEG; s++)
          nxt_seg[s] = ram_ff[s][com_idx_ff] ^ inv_ff;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      com_ff <= {NUM_COM{1'b0}};
      seg_ff <= {NUM_SEG{1'b0}};
    end
    else
    begin
      com_ff <= nxt_com;
      seg_ff <= nxt_seg;
    end
  end

endmodule : ledsd_top

// ### ledsd_monitor.sv
`timescale 1ns/1ps
module ledsd_monitor
  import ledsd_pkg::*;
(
  // clock and reset
  input wire logic               aclk,
  input wire logic               aresetn,
  // bus answers
  input wire logic [1:0]         s_bresp,
  input wire logic               s_bvalid,
  input wire logic               s_bready,
  input wire logic               s_arready,
  input wire logic [31:0]        s_rdata,
  input wire logic               s_rvalid,
  input wire logic               s_rready,
  // display pins
  input wire logic [NUM_COM-1:0] common_output,
  input wire logic [NUM_SEG-1:0] segment_output,
  input wire logic               light_emitter_active,
  input wire logic [6:0]         port0_segment_en,
  input wire logic [6:0]         port2_segment_en
);
  default clocking mon_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  //////////////////////////////////////////////////////////////////////////
  // drive lags the mode bit, so judge it only once the bit has settled
  sequence s_led_settled;
    light_emitter_active [*3];
  endsequence
  sequence s_new_common;
    $changed(common_output) && common_output != '1;
  endsequence
  AST_B_HOLD: assert property (s_bvalid && !s_bready
    |=> s_bvalid && $stable(s_bresp)) else $error("write answer dropped");
  AST_R_HOLD: assert property (s_rvalid && !s_rready
    |=> s_rvalid && $stable(s_rdata)) else $error("read answer dropped");
  AST_AR_BLOCK: assert property (s_rvalid |-> !s_arready)
    else $error("read taken while answer pending");
  AST_RDATA_TOP: assert property (s_rvalid |-> s_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  AST_ONE_COMMON: assert property (
    s_led_settled |-> $countones(~common_output) <= 1)
    else $error("more than one common sinking");
  AST_DEAD_TIME: assert property (
    s_led_settled ##0 s_new_common |-> $past(common_output) == '1)
    else $error("no dead time between commons");
  AST_SPARE_SEGS: assert property (s_led_settled |->
    segment_output[NUM_SEG-1:LED_SEGS] == {17{segment_output[NUM_SEG-1]}})
    else $error("unused segment moves in led mode");
  AST_P0_TOP: assert property (
    (~port0_segment_en & (~port0_segment_en + 7'h01)) == 7'h00)
    else $error("port0 segment pins not taken from the top");
  AST_P2_SHAPE: assert property (!port2_segment_en[0] &&
    (~port2_segment_en[6:4] & (~port2_segment_en[6:4] + 3'h1)) == 3'h0 &&
    (~port2_segment_en[3:1] & (~port2_segment_en[3:1] + 3'h1)) == 3'h0)
    else $error("port2 segment pins out of shape");
endmodule : ledsd_monitor

bind ledsd_top ledsd_monitor ledsd_monitor_inst (.aclk, .aresetn, .s_bresp,
  .s_bvalid, .s_bready, .s_arready, .s_rdata, .s_rvalid, .s_rready,
  .common_output, .segment_output, .light_emitter_active,
  .port0_segment_en, .port2_segment_en);

// ### ledsd_panel_model.sv
`timescale 1ns/1ps
module ledsd_panel_model
  import ledsd_pkg::*;
(
  // pins seen by the matrix
  input wire logic                aclk,
  input wire logic [NUM_COM-1:0]  common_output,
  input wire logic [LED_SEGS-1:0] segment_output,
  input wire logic                light_emitter_active,
  // what the matrix showed
  output logic [NUM_COM-1:0][LED_SEGS-1:0] lit,
  output int                      acts,
  output int                      cnt3,
  output int                      order_err,
  output int                      gap
);
  logic [NUM_COM-1:0] prev;
  int                 last;
  int                 run;
  int                 k;
  initial {acts, cnt3, order_err, run, last} = '0;
  always @(posedge aclk)
  begin
    run = run + 1;
    k = -1;
    for (int i = 0; i < NUM_COM; i++)
      if (!common_output[i] && $countones(~common_output) == 1) k = i;
    // a pixel row lights only while its one common sinks
    if (light_emitter_active && k >= 0)
    begin
      lit[k] = segment_output;
      if (common_output != prev)
      begin
        if (k != 0 && k != last + 1) order_err = order_err + 1;
        last = k;
        acts = acts + 1;
        cnt3 = cnt3 + int'(k == 3);
        gap = run;
        run = 0;
      end
    end
    prev = common_output;
  end
endmodule : ledsd_panel_model

// ### ledsd_bench.sv
`timescale 1ns/1ps
module ledsd_bench;
  import ledsd_pkg::*;
  logic                aclk, aresetn, slow_clock, sub_clock;
  ledsd_addr_t         s_awaddr, s_araddr;
  logic [31:0]         s_wdata, s_rdata, rv;
  logic [3:0]          s_wstrb;
  logic                s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic                s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]          s_bresp, s_rresp, rs;
  logic [NUM_COM-1:0]  common_output;
  logic [NUM_SEG-1:0]  segment_output;
  logic                light_emitter_active, pol;
  logic [6:0]          port0_segment_en, port2_segment_en;
  logic [NUM_COM-1:0][LED_SEGS-1:0] lit;
  int                  acts, cnt3, order_err, gap, miscompares, checked;
  int                  i, n, t;
  logic [7:0]          ram [NUM_SEG];
  logic [7:0]          v8;
  logic [2:0]          div;
  int                  ta [4] = '{8, 16, 256, 512};
  logic [5:0]          st [4] = '{SLOT_TICKS_0, SLOT_TICKS_1, SLOT_TICKS_2,
                                  SLOT_TICKS_3};
  ledsd_top ledsd_top_inst (.aclk, .aresetn, .s_awaddr, .s_awvalid,
    .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
    .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready, .slow_clock, .sub_clock,
    .common_output, .segment_output, .light_emitter_active,
    .port0_segment_en, .port2_segment_en);
  ledsd_panel_model ledsd_panel_model_inst (.aclk, .common_output,
    .segment_output(segment_output[LED_SEGS-1:0]), .light_emitter_active,
    .lit, .acts, .cnt3, .order_err, .gap);
  //////////////////////////////////////////////////////////////////////////
  always #5 aclk = ~aclk;
  always @(posedge aclk)
  begin
    div <= div + 3'h1;
    slow_clock <= div[2];
    sub_clock <= div[0];
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic hang();
    miscompares++;
    close_out();
  endtask : hang
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input ledsd_addr_t a, input logic [7:0] d);
    int j;
    logic [2:0] h;
    @(posedge aclk);
    {s_awaddr, s_wdata} <= {a, 24'h0, d};
    {s_awvalid, s_wvalid, s_bready} <= 3'h7;
    for (j = 0; j < 100; j++)
    begin
      @(negedge aclk);
      {h, rs} = {s_bvalid, s_awready, s_wready, s_bresp};
      @(posedge aclk);
      if (h[2]) break;
      if (h[1]) s_awvalid <= 1'b0;
      if (h[0]) s_wvalid <= 1'b0;
    end
    s_bready <= 1'b0;
    if (j == 100) hang();
  endtask : wr
  task automatic rd(input ledsd_addr_t a);
    int j;
    logic [1:0] h;
    @(posedge aclk);
    s_araddr <= a;
    {s_arvalid, s_rready} <= 2'h3;
    for (j = 0; j < 100; j++)
    begin
      @(negedge aclk);
      {h, rs, rv} = {s_rvalid, s_arready, s_rresp, s_rdata};
      @(posedge aclk);
      if (h[1]) break;
      if (h[0]) s_arvalid <= 1'b0;
    end
    s_rready <= 1'b0;
    if (j == 100) hang();
  endtask : rd
  task automatic wait_acts(input int k);
    int j, t0;
    t0 = acts;
    for (j = 0; j < 30000 && acts < t0 + k; j++) @(posedge aclk);
    if (j == 30000) hang();
  endtask : wait_acts
  function automatic ledsd_addr_t ad(input ledsd_idx_t x);
    return ledsd_addr_t'({x, 2'b00});
  endfunction : ad
  function automatic logic [9:0] lvl(input int k, input logic p);
    for (int s = 0; s < LED_SEGS; s++) lvl[s] = ~(ram[s][k] ^ p);
  endfunction : lvl
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    {aclk, aresetn, div, s_awaddr, s_araddr, s_wdata} = '0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    s_wstrb = 4'h1;
    {miscompares, checked} = '0;
    void'($urandom(32'hce9173b7));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    chk("com", common_output, 4'h0);
    rd(ad(PINFN_IDX));
    chk("pinfn", rv, 32'h7f);
    chk("p0en", port0_segment_en, 7'h7f);
    chk("p2en", port2_segment_en, 7'h7e);
    rd(ad(DCTL_IDX));
    chk("dctl", rv, 32'h12);
    rd(ad(DCTL2_IDX));
    chk("dctl2", rv, 32'h11);
    rd(18'h0);
    chk("rresp", {rs, rv[29:0]}, {RESP_SLVERR, 30'h0});
    wr(ad(RAM_BASE_IDX + 16'h1b), 8'hff);
    chk("bresp", rs, RESP_SLVERR);
    for (i = 0; i < 12; i++)
    begin
      v8 = i < 8 ? {1'b1, 2'(i), 2'(i), 3'(i)} : 8'($urandom);
      wr(ad(PINFN_IDX), v8);
      rd(ad(PINFN_IDX));
      chk("pinfn", rv, {24'h0, v8 & PINFN_WMASK});
      chk("p0en", port0_segment_en, 7'(7'h7f << (7 - v8[2:0])));
      chk("p2en", port2_segment_en, {3'h7 << (3 - v8[6:5]),
          3'h7 << (3 - v8[4:3]), 1'b0});
    end
    for (i = 0; i < NUM_SEG; i++)
    begin
      v8 = i == 1 ? 8'h00 : i < 4 || i == 9 ? 8'hff : 8'($urandom);
      wr(ad(RAM_BASE_IDX + 16'(i)), v8);
      ram[i] = v8 & (i < 4 ? 8'hff >> (4 - i) : 8'hff);
      rd(ad(RAM_BASE_IDX + 16'(i)));
      chk("ram", rv, {24'h0, ram[i]});
    end
    for (t = 0; t < 2; t++)
    begin
      pol = 1'($urandom_range(1, 0));
      wr(ad(DCTL2_IDX), {2'h0, 1'b1, pol, 4'h0});
      wr(ad(DCTL_IDX), {1'b1, t ? DUTY_QUARTER : DUTY_THIRD, 4'h0});
      n = cnt3;
      wait_acts(10);
      chk("led", light_emitter_active, 1'b1);
      chk("cnt3", 32'(cnt3 > n), t);
      chk("order", order_err, 0);
      for (i = 0; i < 3 + t; i++) chk("lit", lit[i], lvl(i, pol));
    end
    for (n = 0; n < 10; n++)
    begin
      i = n < 8 ? n / 4 : n - 6;
      t = n < 8 ? n % 4 : 0;
      wr(ad(DCTL_IDX), {1'b1, DUTY_QUARTER, 2'(i), 2'(t)});
      wait_acts(3);
      chk("gap", gap, st[t] * ta[i]);
    end
    wr(ad(DCTL_IDX), {1'b0, DUTY_QUARTER, 4'h0});
    n = acts;
    repeat (200) @(posedge aclk);
    chk("com", common_output, 4'hf);
    chk("seg", segment_output[9:0], {10{~pol}});
    chk("acts", acts, n);
    rd(ad(RAM_BASE_IDX + 16'h5));
    chk("ram", rv, {24'h0, ram[5]});
    wr(ad(DCTL2_IDX), 8'h10);
    repeat (3) @(posedge aclk);
    chk("lcd", {light_emitter_active, common_output, segment_output},
        32'h0);
    close_out();
  end
endmodule : ledsd_bench
